// file: cec_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Trigger enable low blocks all ADC events
// - Source field picks positive input source
// - Trigger sense: level, fall, rise, either
// - Trigger level bit picks active level
// - Interrupt sense: level, fall, rise, either
// - Interrupt level bit picks active level
// - Invert bit flips result before sensing
// - Status bit shows present comparator output
module cec_top
  import cec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        cmp_raw,
  output var  logic [1:0]  cmp_src_sel,
  output var  logic        adc_event,
  output var  logic        irq
);

  // Configuration state
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [1:0]  mask_q;
  logic [1:0]  mask_d;
  logic [1:0]  istat_q;
  logic [1:0]  istat_d;

  // Bus handshake state
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Datapath state
  logic        cmp_cond_q;
  logic        adc_event_q;
  logic        irq_q;
  logic [1:0]  src_sel_q;

  // Decoded fields
  logic        f_inv;
  logic [1:0]  f_interrupt_sense;
  logic        f_interrupt_level_value;
  logic [1:0]  f_adc_trigger_sense;
  logic        f_adc_trigger_level_value;
  logic [1:0]  f_src;
  logic        f_adc_trigger_output_enable;

  // Bus decode
  logic        setup_ph;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  logic        sel_istat;
  logic        sel_mask;
  logic        sel_cstat;
  logic        sel_ctrl;
  logic        addr_hit;
  logic        wr_ctrl;
  logic        wr_mask;
  logic [31:0] rd_mux;
  logic [31:0] wr_bytes;

  // Event sources
  logic        int_hit;
  logic        adc_hit;
  logic        adc_fire;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;
  logic [1:0]  pend;

  // Field extraction
  assign f_inv    = ctrl_q[CTL_INV_BIT];
  assign f_interrupt_sense   = ctrl_q[CTL_INTERRUPT_SENSE_LO +: 2];
  assign f_interrupt_level_value = ctrl_q[CTL_INTERRUPT_LEVEL_VALUE_BIT];
  assign f_adc_trigger_sense   = ctrl_q[CTL_ADC_TRIGGER_SENSE_LO +: 2];
  assign f_adc_trigger_level_value = ctrl_q[CTL_ADC_TRIGGER_LEVEL_VALUE_BIT];
  assign f_src    = ctrl_q[CTL_SRC_LO +: 2];
  assign f_adc_trigger_output_enable   = ctrl_q[CTL_ADC_TRIGGER_OUTPUT_ENABLE_BIT];

  // APB phases: no wait state, answer on first access cycle
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready_q;
  assign wr_done     = access_done & pwrite;
  assign rd_done     = access_done & ~pwrite;

  // Address decode on word boundaries
  assign sel_istat = (paddr[11:2] == OFS_INT_STATUS[11:2]);
  assign sel_mask  = (paddr[11:2] == OFS_INT_MASK[11:2]);
  assign sel_cstat = (paddr[11:2] == OFS_CMP_STATUS[11:2]);
  assign sel_ctrl  = (paddr[11:2] == OFS_CMP_CTRL[11:2]);
  assign addr_hit  = sel_istat | sel_mask | sel_cstat | sel_ctrl;

  // Register write strobes
  assign wr_ctrl = wr_done & sel_ctrl;
  assign wr_mask = wr_done & sel_mask & pstrb[0];

  // Byte-lane expansion of the write strobes
  assign wr_bytes = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Read multiplexer; reserved bits read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_istat)
    begin
      rd_mux[IRQ_W-1:0] = istat_q;
    end
    else if (sel_mask)
    begin
      rd_mux[IRQ_W-1:0] = mask_q;
    end
    else if (sel_cstat)
    begin
      rd_mux[STAT_CURRENT_OUTPUT_VALUE_BIT] = cmp_cond_q;
    end
    else if (sel_ctrl)
    begin
      rd_mux = ctrl_q;
    end
  end

  // Ready: raised in the cycle after every setup phase, so no wait state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup_ph;
    end
  end

  // Error answer for addresses outside the map
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pslverr_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      pslverr_q <= ~addr_hit;
    end
    else if (access_done)
    begin
      pslverr_q <= 1'b0;
    end
  end

  // Read data taken at setup, zero outside the answer cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_ph)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else if (access_done)
    begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Control register, writable fields only
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d = (ctrl_q & ~(wr_bytes & CTL_WR_MASK))
             | (pwdata & wr_bytes & CTL_WR_MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTL_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Interrupt mask register
  always_comb
  begin
    mask_d = mask_q;
    if (wr_mask)
    begin
      mask_d = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= MASK_RESET;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // Conditioned comparator output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_cond_q <= 1'b0;
    end
    else
    begin
      cmp_cond_q <= cmp_raw ^ f_inv;
    end
  end

  // Positive input source select; reserved code falls back to own pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_sel_q <= SRC_OWN_PIN;
    end
    else
    begin
      unique case (f_src)
        SRC_OWN_PIN:  src_sel_q <= SRC_OWN_PIN;
        SRC_CMP0_PIN: src_sel_q <= SRC_CMP0_PIN;
        SRC_VREF:     src_sel_q <= SRC_VREF;
        SRC_RSVD:     src_sel_q <= SRC_OWN_PIN;
      endcase
    end
  end

  // Interrupt condition qualifier
  cec_sense u_int_sense
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .sig       (cmp_cond_q),
    .sense     (f_interrupt_sense),
    .level_val (f_interrupt_level_value),
    .hit       (int_hit)
  );

  // ADC trigger qualifier
  cec_sense u_adc_sense
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .sig       (cmp_cond_q),
    .sense     (f_adc_trigger_sense),
    .level_val (f_adc_trigger_level_value),
    .hit       (adc_hit)
  );

  // Delivery gate toward the ADC
  assign adc_fire = adc_hit & f_adc_trigger_output_enable;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_event_q <= 1'b0;
    end
    else
    begin
      adc_event_q <= adc_fire;
    end
  end

  // Sticky interrupt status; a read clears what it returned
  assign ev_set[IRQ_CMP_BIT] = int_hit;
  assign ev_set[IRQ_ADC_BIT] = adc_fire;
  assign ev_clr = (rd_done && sel_istat) ? prdata_q[IRQ_W-1:0] : 2'h0;

  // Set wins over a same-cycle clear
  always_comb
  begin
    istat_d = (istat_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_q <= IRQ_RESET;
    end
    else
    begin
      istat_q <= istat_d;
    end
  end

  // Unmasked pending events
  assign pend = istat_q & mask_q;

  // Level interrupt output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |pend;
    end
  end

  // Outputs
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign cmp_src_sel = src_sel_q;
  assign adc_event   = adc_event_q;
  assign irq         = irq_q;

endmodule // cec_top

`default_nettype wire

// file: cec_pkg.sv
package cec_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_INT_STATUS = 12'h000;
  localparam logic [11:0] OFS_INT_MASK   = 12'h004;
  localparam logic [11:0] OFS_CMP_STATUS = 12'h020;
  localparam logic [11:0] OFS_CMP_CTRL   = 12'h024;

  // Control register fields
  localparam int unsigned CTL_INV_BIT    = 1;
  localparam int unsigned CTL_INTERRUPT_SENSE_LO    = 2;
  localparam int unsigned CTL_INTERRUPT_LEVEL_VALUE_BIT = 4;
  localparam int unsigned CTL_ADC_TRIGGER_SENSE_LO    = 5;
  localparam int unsigned CTL_ADC_TRIGGER_LEVEL_VALUE_BIT = 7;
  localparam int unsigned CTL_SRC_LO     = 9;
  localparam int unsigned CTL_ADC_TRIGGER_OUTPUT_ENABLE_BIT   = 11;
  localparam logic [31:0] CTL_WR_MASK    = 32'h0000_0efe;
  localparam logic [31:0] CTL_RESET      = 32'h0000_0000;

  // Comparator status register field
  localparam int unsigned STAT_CURRENT_OUTPUT_VALUE_BIT  = 1;

  // Interrupt status / mask layout
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_CMP_BIT    = 0;
  localparam int unsigned IRQ_ADC_BIT    = 1;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam logic [1:0]  MASK_RESET     = 2'h0;

  // Sense encodings, shared by interrupt and trigger paths
  localparam logic [1:0]  SENSE_LEVEL    = 2'h0;
  localparam logic [1:0]  SENSE_FALL     = 2'h1;
  localparam logic [1:0]  SENSE_RISE     = 2'h2;
  localparam logic [1:0]  SENSE_BOTH     = 2'h3;

  // Positive input source encodings
  localparam logic [1:0]  SRC_OWN_PIN    = 2'h0;
  localparam logic [1:0]  SRC_CMP0_PIN   = 2'h1;
  localparam logic [1:0]  SRC_VREF       = 2'h2;
  localparam logic [1:0]  SRC_RSVD       = 2'h3;

endpackage

// file: cec_sense.sv
`timescale 1ns/10ps
`default_nettype none

module cec_sense
  import cec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sig,
  input  wire logic [1:0] sense,
  input  wire logic       level_val,
  output var  logic       hit
);

  logic prev_q;
  logic primed_q;
  logic rise;
  logic fall;

  // Previous value of the conditioned output
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q   <= 1'b0;
      primed_q <= 1'b0;
    end
    else
    begin
      prev_q   <= sig;
      primed_q <= 1'b1;
    end
  end

  // No edge reported before a previous value exists
  assign rise = primed_q & sig & ~prev_q;
  assign fall = primed_q & ~sig & prev_q;

  always_comb
  begin
    unique case (sense)
      SENSE_LEVEL: hit = (sig == level_val);
      SENSE_FALL:  hit = fall;
      SENSE_RISE:  hit = rise;
      SENSE_BOTH:  hit = rise | fall;
    endcase
  end

endmodule // cec_sense

`default_nettype wire

// file: cec_adc_sink.sv
`timescale 1ns/10ps
`default_nettype none
module cec_adc_sink
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        adc_event,
  output var  logic [15:0] ev_cnt
);
  // Sequencer starts, one per event cycle
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ev_cnt <= 16'h0000;
    else if (adc_event)
      ev_cnt <= ev_cnt + 16'h0001;
endmodule // cec_adc_sink
`default_nettype wire

// file: cec_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cec_top_chk
  import cec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        cmp_raw,
  input wire logic [1:0]  cmp_src_sel,
  input wire logic        adc_event,
  input wire logic        irq
);
  logic [11:0] ctl_q;
  logic [1:0]  msk_q;
  logic [2:0]  qt_q;
  wire         wr = psel && penable && pready && pwrite;
  wire         s = qt_q > 3'h4;
  wire [11:0]  ln = {{4{pstrb[1]}}, {8{pstrb[0]}}} & CTL_WR_MASK[11:0];
  // Shadow of control and mask, cycles since last write
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctl_q <= 12'h000;
      msk_q <= 2'h0;
      qt_q <= 3'h0;
    end
    else
    begin
      if (wr && paddr == OFS_CMP_CTRL)
        ctl_q <= (ctl_q & ~ln) | (pwdata[11:0] & ln);
      if (wr && paddr == OFS_INT_MASK && pstrb[0])
        msk_q <= pwdata[1:0];
      qt_q <= wr ? 3'h0 : qt_q + 3'(qt_q != 3'h7);
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_gate_off: assert property (s && !ctl_q[11] |-> !adc_event)
    else $error("event not gated");
  a_trig_rise: assert property (s && ctl_q[11] && ctl_q[6:5] == 2'h2 |->
    adc_event == ($past(cmp_raw, 2) != ctl_q[1] && $past(cmp_raw, 3) == ctl_q[1]))
    else $error("rise event wrong");
  a_trig_fall: assert property (s && ctl_q[11] && ctl_q[6:5] == 2'h1 |->
    adc_event == ($past(cmp_raw, 2) == ctl_q[1] && $past(cmp_raw, 3) != ctl_q[1]))
    else $error("fall event wrong");
  a_trig_both: assert property (s && ctl_q[11] && ctl_q[6:5] == 2'h3 |->
    adc_event == ($past(cmp_raw, 2) != $past(cmp_raw, 3)))
    else $error("either edge event wrong");
  a_trig_level: assert property (s && ctl_q[11] && ctl_q[6:5] == 2'h0 |->
    adc_event == (($past(cmp_raw, 2) ^ ctl_q[1]) == ctl_q[7]))
    else $error("level event wrong");
  a_src_select: assert property (s |->
    cmp_src_sel == (ctl_q[10:9] == 2'h3 ? 2'h0 : ctl_q[10:9]))
    else $error("source select wrong");
  a_irq_level: assert property (s && msk_q[0] && ctl_q[3:2] == 2'h0 &&
    ($past(cmp_raw, 3) ^ ctl_q[1]) == ctl_q[4] |-> irq)
    else $error("level irq missing");
  a_current_output_value_read: assert property (s && psel && penable && pready && !pwrite &&
    paddr == OFS_CMP_STATUS && $past(cmp_raw, 1) == $past(cmp_raw, 3) &&
    $past(cmp_raw, 2) == $past(cmp_raw, 3) |-> prdata[1] == ($past(cmp_raw, 2) ^ ctl_q[1]))
    else $error("output value read wrong");
  c_rise: cover property (adc_event && ctl_q[6:5] == 2'h2);
  c_level: cover property (adc_event && ctl_q[6:5] == 2'h0);
  c_irq: cover property (irq && msk_q[0]);
endmodule // cec_top_chk
bind cec_top cec_top_chk cec_top_chk_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pstrb, .prdata, .pready, .cmp_raw, .cmp_src_sel, .adc_event, .irq);
`default_nettype wire

// file: cec_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cec_top_bench;
  import cec_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        cmp_raw = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  cmp_src_sel;
  logic        adc_event;
  logic        irq;
  logic [15:0] ev_cnt;
  logic [7:0]  rnd = 8'h04;
  int          err_total = 0;
  int          checks_done = 0;
  always #2 clk = ~clk;
  cec_top cec_top_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cmp_raw, .cmp_src_sel, .adc_event, .irq);
  cec_adc_sink cec_adc_sink_i (.clk, .rst_n, .adc_event, .ev_cnt);
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic hit(input logic [1:0] sn, input logic lv, input logic c2,
                               input logic c3);
    case (sn)
      2'h0: return c2 == lv;
      2'h1: return !c2 && c3;
      2'h2: return c2 && !c3;
      default: return c2 != c3;
    endcase
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic        x;
    logic        ai;
    logic        aa;
    logic [2:0]  h;
    logic [11:0] ct;
    logic [15:0] s0;
    int          ne;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset outputs", 32'h0, {26'h0, pslverr, irq, adc_event, cmp_src_sel, pready});
    apb(OFS_CMP_CTRL, 1'b0, 32'h0, q, e);
    chk("ctl reset", CTL_RESET, q);
    apb(12'h100, 1'b0, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, e});
    for (int i = 0; i < 32; i++)
    begin
      ct = {i[4], i[1:0], 1'b0, i[2], i[1:0], ~i[2], i[3:2], i[3], 1'b0};
      apb(OFS_CMP_CTRL, 1'b1, {20'hfffff, ct | 12'h101}, q, e);
      apb(OFS_INT_MASK, 1'b1, {30'h0, i[1:0]}, q, e);
      apb(OFS_CMP_CTRL, 1'b0, 32'h0, q, e);
      chk("ctl", {20'h0, ct}, q);
      repeat (4) @(posedge clk);
      apb(OFS_INT_STATUS, 1'b0, 32'h0, q, e);
      h = {3{cmp_raw}};
      ai = 1'b0;
      aa = 1'b0;
      ne = 0;
      for (int j = 0; j < 30; j++)
      begin
        @(posedge clk);
        if (j == 0)
          s0 = ev_cnt;
        chk("partner", 32'(ne), 32'(ev_cnt - s0));
        ai = ai | hit(ct[3:2], ct[4], h[1] ^ ct[1], h[2] ^ ct[1]);
        x = ct[11] & hit(ct[6:5], ct[7], h[1] ^ ct[1], h[2] ^ ct[1]);
        chk("adc", {31'h0, x}, {31'h0, adc_event});
        aa = aa | x;
        ne += 32'(x);
        h = {h[1:0], cmp_raw};
        rnd = lfsr(rnd);
        if (j < 24)
          cmp_raw <= rnd[0];
      end
      chk("src", ct[10:9] == 2'h3 ? 32'h0 : 32'(ct[10:9]), 32'(cmp_src_sel));
      chk("irq", 32'((ai & i[0]) | (aa & i[1])), 32'(irq));
      apb(OFS_INT_STATUS, 1'b0, 32'h0, q, e);
      chk("status", {30'h0, aa, ai}, q);
      apb(OFS_CMP_STATUS, 1'b0, 32'h0, q, e);
      chk("current_output_value", {30'h0, h[0] ^ ct[1], 1'b0}, q);
      x = h[0] ^ ct[1];
      ai = hit(ct[3:2], ct[4], x, x);
      aa = ct[11] & hit(ct[6:5], ct[7], x, x);
      apb(OFS_INT_STATUS, 1'b0, 32'h0, q, e);
      chk("cleared", {30'h0, aa, ai}, q);
    end
    pstrb <= 4'h2;
    apb(OFS_CMP_CTRL, 1'b1, 32'h0, q, e);
    pstrb <= 4'hf;
    apb(OFS_CMP_CTRL, 1'b0, 32'h0, q, e);
    chk("lane write", {24'h0, ct[7:0]}, q);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule // cec_top_bench
`default_nettype wire
